// [dcc_pkg.sv]
// Constants and types for the core control register block.
// Assumes a single core clock and a plain register port.
package dcc_pkg;

    // Register port widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    // Register offset
    localparam logic [3:0] CORE_CONTROL_OFFSET = 4'h0;

    // Field positions
    localparam int MUL_SIGN_HI = 13;
    localparam int MUL_SIGN_LO = 12;
    localparam int LOOP_TERM_BIT = 11;
    localparam int LOOP_DEPTH_HI = 10;
    localparam int LOOP_DEPTH_LO = 8;
    localparam int SAT_A_BIT = 7;
    localparam int SAT_B_BIT = 6;
    localparam int STORE_SAT_BIT = 5;
    localparam int SAT_POINT_BIT = 4;
    localparam int PRIO_MSB_BIT = 3;

    // Field encodings
    localparam logic [1:0] MUL_SIGNED_CODE = 2'h0;
    localparam logic [1:0] MUL_UNSIGNED_CODE = 2'h1;
    localparam logic [2:0] LOOP_DEPTH_NONE = 3'h0;
    localparam logic [2:0] LOOP_DEPTH_MAX = 3'h7;
    localparam logic [2:0] LOOP_DEPTH_ONE = 3'h1;

    // Configuration carried to the engine
    typedef struct packed {
        logic [1:0] multiply_signedness;
        logic accum_a_sat_enable;
        logic accum_b_sat_enable;
        logic store_saturation_enable;
        logic saturation_point_select;
    } dcc_cfg_type;

    // Reset values
    localparam dcc_cfg_type CFG_RESET = '{
        multiply_signedness: 2'h0,
        accum_a_sat_enable: 1'b0,
        accum_b_sat_enable: 1'b0,
        store_saturation_enable: 1'b1,
        saturation_point_select: 1'b0
    };
    localparam logic PRIO_MSB_RESET = 1'b0;

endpackage

// [dcc_core_control.sv]
// Core control register: engine configuration and core state.
// Assumes loop and priority inputs come from core-clock logic.
`timescale 1ns/1ps
module dcc_core_control
    import dcc_pkg::*;
(
    input wire logic i_clk, // Core clock, 100 MHz
    input wire logic i_rst_n, // Async reset, active low
    input wire logic [ADDR_W-1:0] i_addr, // Register address
    input wire logic [DATA_W-1:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [DATA_W-1:0] o_rdata, // Read data, next cycle
    input wire logic i_loop_start, // Loop entered, pulse
    input wire logic i_loop_iter_end, // Iteration closes, pulse
    input wire logic i_loop_done, // Loop ends by count, pulse
    input wire logic i_prio_msb_set, // Core raises top bit
    input wire logic [2:0] i_status_prio, // Status word priority
    output dcc_cfg_type o_cfg, // Engine configuration
    output logic o_mul_unsigned, // Multiplies unsigned
    output logic [2:0] o_loop_depth, // Active loop depth
    output logic o_loop_terminate, // Early exit pending
    output logic o_loop_exit, // Early exit taken, pulse
    output logic [3:0] o_cpu_priority_level // Full priority level
);

    // Decoded register access
    logic hit;
    logic wr_cc;
    logic rd_cc;
    assign hit = (i_addr == CORE_CONTROL_OFFSET);
    assign wr_cc = i_wr & hit;
    assign rd_cc = i_rd & hit;

    // Configuration group
    dcc_cfg_type cfg_r;
    dcc_cfg_type cfg_nxt;
    logic mul_uns_r;
    logic mul_uns_nxt;

    // Loop group
    logic [2:0] depth_r;
    logic [2:0] depth_nxt;
    logic term_r;
    logic term_nxt;
    logic exit_r;
    logic exit_nxt;
    logic loop_end;
    logic early_end;

    // Priority group
    logic prio_r;
    logic prio_nxt;
    logic [3:0] level_r;
    logic [3:0] level_nxt;

    // Read group
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [DATA_W-1:0] image;

    // Configuration next values
    always_comb begin
        cfg_nxt = cfg_r;
        if (wr_cc) begin
            cfg_nxt.multiply_signedness = i_wdata[MUL_SIGN_HI:MUL_SIGN_LO];
            cfg_nxt.accum_a_sat_enable = i_wdata[SAT_A_BIT];
            cfg_nxt.accum_b_sat_enable = i_wdata[SAT_B_BIT];
            cfg_nxt.store_saturation_enable = i_wdata[STORE_SAT_BIT];
            cfg_nxt.saturation_point_select = i_wdata[SAT_POINT_BIT];
        end
        // Only code 01 selects unsigned; others stay signed
        mul_uns_nxt = (cfg_nxt.multiply_signedness == MUL_UNSIGNED_CODE);
    end

    // Configuration registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg_r <= CFG_RESET;
            mul_uns_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            mul_uns_r <= mul_uns_nxt;
        end
    end

    // Loop ends by count, or early on a pending request
    assign early_end = term_r & i_loop_iter_end;
    assign loop_end = i_loop_done | early_end;

    // Loop depth and terminate next values
    always_comb begin
        depth_nxt = depth_r;
        // Enter and leave in one cycle keeps the depth
        if (i_loop_start && !loop_end) begin
            if (depth_r != LOOP_DEPTH_MAX) begin
                depth_nxt = depth_r + LOOP_DEPTH_ONE;
            end
        end else if (loop_end && !i_loop_start) begin
            if (depth_r != LOOP_DEPTH_NONE) begin
                depth_nxt = depth_r - LOOP_DEPTH_ONE;
            end
        end
        // Request cleared when taken, a new write wins
        term_nxt = term_r & ~loop_end;
        if (wr_cc && i_wdata[LOOP_TERM_BIT]) begin
            term_nxt = 1'b1;
        end
        // No loop left to end
        if (depth_nxt == LOOP_DEPTH_NONE) begin
            term_nxt = 1'b0;
        end
        exit_nxt = early_end;
    end

    // Loop registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            depth_r <= LOOP_DEPTH_NONE;
            term_r <= 1'b0;
            exit_r <= 1'b0;
        end else begin
            depth_r <= depth_nxt;
            term_r <= term_nxt;
            exit_r <= exit_nxt;
        end
    end

    // Priority top bit: hardware set wins over write clear
    always_comb begin
        prio_nxt = prio_r;
        if (i_prio_msb_set) begin
            prio_nxt = 1'b1;
        end else if (wr_cc && !i_wdata[PRIO_MSB_BIT]) begin
            prio_nxt = 1'b0;
        end
        // Top bit above the status word bits
        level_nxt = {prio_nxt, i_status_prio};
    end

    // Priority registers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prio_r <= PRIO_MSB_RESET;
            level_r <= 4'h0;
        end else begin
            prio_r <= prio_nxt;
            level_r <= level_nxt;
        end
    end

    // Register image; terminate bit always reads zero
    always_comb begin
        image = '0;
        image[MUL_SIGN_HI:MUL_SIGN_LO] = cfg_r.multiply_signedness;
        image[LOOP_TERM_BIT] = 1'b0;
        image[LOOP_DEPTH_HI:LOOP_DEPTH_LO] = depth_r;
        image[SAT_A_BIT] = cfg_r.accum_a_sat_enable;
        image[SAT_B_BIT] = cfg_r.accum_b_sat_enable;
        image[STORE_SAT_BIT] = cfg_r.store_saturation_enable;
        image[SAT_POINT_BIT] = cfg_r.saturation_point_select;
        image[PRIO_MSB_BIT] = prio_r;
        // Unmapped addresses and idle cycles read zero
        rdata_nxt = rd_cc ? image : '0;
    end

    // Read data register
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign o_rdata = rdata_r;
    assign o_cfg = cfg_r;
    assign o_mul_unsigned = mul_uns_r;
    assign o_loop_depth = depth_r;
    assign o_loop_terminate = term_r;
    assign o_loop_exit = exit_r;
    assign o_cpu_priority_level = level_r;

    // Checks on the register behaviour
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // Code 01 gives unsigned multiplies
    property p_mul_unsigned;
        wr_cc && i_wdata[MUL_SIGN_HI:MUL_SIGN_LO] == 2'h1 |=> o_mul_unsigned;
    endproperty
    a_mul_unsigned: assert property (p_mul_unsigned)
        else $error("unsigned code not applied");

    // Code 00 gives signed multiplies
    property p_mul_signed;
        wr_cc && i_wdata[MUL_SIGN_HI:MUL_SIGN_LO] == 2'h0 |=> !o_mul_unsigned;
    endproperty
    a_mul_signed: assert property (p_mul_signed)
        else $error("signed code not applied");

    // Loop entry raises the depth by one
    property p_depth_up;
        i_loop_start && !i_loop_done && !early_end && depth_r != 3'h7
            |=> o_loop_depth == $past(depth_r) + 3'h1;
    endproperty
    a_depth_up: assert property (p_depth_up)
        else $error("loop depth did not rise");

    // Loop end lowers the depth, read back on the bus
    property p_depth_down;
        i_loop_done && !i_loop_start && depth_r != 3'h0 && !i_rd
            ##1 rd_cc |=> o_rdata[10:8] == $past(depth_r, 2) - 3'h1;
    endproperty
    a_depth_down: assert property (p_depth_down)
        else $error("loop depth did not fall");

    // Accumulator A enable follows the write
    property p_sat_a;
        wr_cc |=> o_cfg.accum_a_sat_enable == $past(i_wdata[7]);
    endproperty
    a_sat_a: assert property (p_sat_a)
        else $error("accumulator A enable wrong");

    // Accumulator B enable follows the write
    property p_sat_b;
        wr_cc |=> o_cfg.accum_b_sat_enable == $past(i_wdata[6]);
    endproperty
    a_sat_b: assert property (p_sat_b)
        else $error("accumulator B enable wrong");

    // Store saturation holds without writes
    property p_store_sat;
        !wr_cc |=> $stable(o_cfg.store_saturation_enable);
    endproperty
    a_store_sat: assert property (p_store_sat)
        else $error("store saturation changed unasked");

    // Point select follows the write
    property p_sat_point;
        wr_cc |=> o_cfg.saturation_point_select == $past(i_wdata[4]);
    endproperty
    a_sat_point: assert property (p_sat_point)
        else $error("saturation point select wrong");

    // Writing one never sets the priority top bit
    property p_prio_noset;
        !prio_r && !i_prio_msb_set |=> !prio_r;
    endproperty
    a_prio_noset: assert property (p_prio_noset)
        else $error("priority top bit set by write");

    // Full level joins top bit and status bits
    property p_prio_join;
        ##1 o_cpu_priority_level == {prio_r, $past(i_status_prio)};
    endproperty
    a_prio_join: assert property (p_prio_join)
        else $error("priority level not joined");

    // Terminate bit reads back as zero
    property p_term_read;
        rd_cc |=> !o_rdata[11];
    endproperty
    a_term_read: assert property (p_term_read)
        else $error("terminate bit read as one");

    // Pending request ends the loop at iteration close
    property p_term_exit;
        o_loop_terminate && i_loop_iter_end && !i_loop_start
            |=> o_loop_exit && o_loop_depth == $past(depth_r) - 3'h1;
    endproperty
    a_term_exit: assert property (p_term_exit)
        else $error("early loop exit not taken");

    // Codes 10 and 11 stay signed
    property p_mul_other;
        wr_cc && i_wdata[MUL_SIGN_HI] |=> !o_mul_unsigned;
    endproperty
    a_mul_other: assert property (p_mul_other)
        else $error("codes 10 and 11 not signed");

    // Store saturation enable follows the write
    property p_store_sat_wr;
        wr_cc |=> o_cfg.store_saturation_enable == $past(i_wdata[STORE_SAT_BIT]);
    endproperty
    a_store_sat_wr: assert property (p_store_sat_wr)
        else $error("store saturation enable wrong");

    // Entry and end in one cycle keep the depth
    property p_depth_hold;
        i_loop_start && (i_loop_done || early_end) |=> $stable(o_loop_depth);
    endproperty
    a_depth_hold: assert property (p_depth_hold)
        else $error("loop depth moved on entry with end");

    // Writing zero clears the top bit when the core does not set it
    property p_prio_clear;
        wr_cc && !i_wdata[PRIO_MSB_BIT] && !i_prio_msb_set |=> !prio_r;
    endproperty
    a_prio_clear: assert property (p_prio_clear)
        else $error("priority top bit not cleared");

    // Core set wins over a clearing write
    property p_prio_setwin;
        i_prio_msb_set |=> prio_r;
    endproperty
    a_prio_setwin: assert property (p_prio_setwin)
        else $error("priority top bit set lost");

    // Main scenarios
    c_early_exit: cover property (o_loop_terminate ##[1:20] o_loop_exit);
    c_deep_nest: cover property (o_loop_depth == 3'h3);
    c_prio_clear: cover property (prio_r ##1 !prio_r);
    c_unsigned: cover property (!o_mul_unsigned ##1 o_mul_unsigned);
    c_depth_hold: cover property (i_loop_start && i_loop_done);

endmodule // dcc_core_control

// [dcc_testbench.sv]
// Self-checking bench for the core control register block.
// Assumes the design's own assertions sit inside its files; one core clock.
`timescale 1ns/1ps
module testbench;
    import dcc_pkg::*;

    logic i_clk; // Core clock
    logic i_rst_n; // Async reset, active low
    logic [ADDR_W-1:0] i_addr; // Register address
    logic [DATA_W-1:0] i_wdata; // Write data
    logic i_wr; // Write strobe
    logic i_rd; // Read strobe
    logic [DATA_W-1:0] o_rdata; // Read data
    logic i_loop_start, i_loop_iter_end, i_loop_done; // Loop events
    logic i_prio_msb_set; // Top bit set source
    logic [2:0] i_status_prio; // Status word priority
    dcc_cfg_type o_cfg; // Engine configuration
    logic o_mul_unsigned, o_loop_terminate, o_loop_exit; // Status flags
    logic [2:0] o_loop_depth; // Loop depth
    logic [3:0] o_cpu_priority_level; // Full priority level
    integer seed = 92678; // Fixed seed
    integer err_count = 0; // Mismatches
    integer total_checks = 0; // Comparisons
    logic [31:0] r0; // Random word
    logic [15:0] exp_q[$]; // Expected read images
    logic rd_q; // Read seen last edge
    // Reference state, committed at each sampling edge
    logic [1:0] m_sgn = 2'h0;
    logic m_a = 1'b0, m_b = 1'b0, m_st = 1'b1, m_pt = 1'b0, m_prio = 1'b0;
    logic m_term = 1'b0, m_exit = 1'b0;
    logic [2:0] m_dep = 3'h0, m_stat = 3'h0;

    dcc_core_control i_dcc_core_control (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_loop_start(i_loop_start),
        .i_loop_iter_end(i_loop_iter_end), .i_loop_done(i_loop_done), .i_prio_msb_set(i_prio_msb_set),
        .i_status_prio(i_status_prio), .o_cfg(o_cfg), .o_mul_unsigned(o_mul_unsigned),
        .o_loop_depth(o_loop_depth), .o_loop_terminate(o_loop_terminate), .o_loop_exit(o_loop_exit),
        .o_cpu_priority_level(o_cpu_priority_level));

    // Clock, 10 ns period
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // Register image from reference state
    function automatic logic [15:0] img();
        return {2'h0, m_sgn, 1'b0, m_dep, m_a, m_b, m_st, m_pt, m_prio, 3'h0};
    endfunction

    // One compare for every kind of result
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic final_report();
        if (err_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One cycle of stimulus, reference updated at the sampling edge
    task automatic step(input logic w, r, input logic [3:0] a, input logic [15:0] d,
                        input logic s, ie, dn, ps);
        logic [2:0] st, dep;
        logic ends, hit, term, prio;
        st = 3'($random(seed));
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wdata <= d;
        i_loop_start <= s;
        i_loop_iter_end <= ie;
        i_loop_done <= dn;
        i_prio_msb_set <= ps;
        i_status_prio <= st;
        if (r) exp_q.push_back(a == CORE_CONTROL_OFFSET ? img() : 16'h0000);
        hit = w && a == CORE_CONTROL_OFFSET;
        ends = dn || (ie && m_term);
        dep = (s && !ends && m_dep != 3'h7) ? m_dep + 3'h1 :
              (ends && !s && m_dep != 3'h0) ? m_dep - 3'h1 : m_dep;
        term = (hit && d[11] && dep != 3'h0) ? 1'b1 : (ends || dep == 3'h0) ? 1'b0 : m_term;
        prio = ps ? 1'b1 : (hit && !d[3]) ? 1'b0 : m_prio;
        @(posedge i_clk);
        m_exit = ie && m_term && m_dep != 3'h0;
        m_dep = dep;
        m_term = term;
        m_prio = prio;
        m_stat = st;
        if (hit) {m_sgn, m_a, m_b, m_st, m_pt} = {d[13:12], d[7:4]};
    endtask

    // Read strobe seen by the design at this edge
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) rd_q <= 1'b0;
        else rd_q <= i_rd;
    end

    // Watches every output where it is settled
    always @(negedge i_clk) begin
        if (i_rst_n) begin
            if (rd_q && exp_q.size() > 0) chk("rdata", exp_q.pop_front(), o_rdata);
            else chk("rdata idle", 16'h0000, o_rdata);
            chk("mul_unsigned", 16'(m_sgn == 2'h1), 16'(o_mul_unsigned));
            chk("cfg", 16'({m_sgn, m_a, m_b, m_st, m_pt}), 16'(o_cfg));
            chk("depth", 16'(m_dep), 16'(o_loop_depth));
            chk("terminate", 16'(m_term), 16'(o_loop_terminate));
            chk("exit", 16'(m_exit), 16'(o_loop_exit));
            chk("priority", 16'({m_prio, m_stat}), 16'(o_cpu_priority_level));
        end
    end

    // Hang guard, far beyond the planned few hundred cycles
    initial begin
        #50000;
        err_count++;
        final_report();
    end

    // Main sequence
    initial begin
        {i_addr, i_wdata, i_wr, i_rd, i_loop_start, i_loop_iter_end} = '0;
        {i_loop_done, i_prio_msb_set, i_status_prio} = '0;
        i_rst_n = 1'b0;
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        step(0, 1, 4'h0, 16'h0000, 0, 0, 0, 0);
        // Depth rises to its top and holds
        repeat (9) step(0, 0, 4'h0, 16'h0000, 1, 0, 0, 0);
        step(0, 1, 4'h0, 16'h0000, 0, 0, 0, 0);
        // Entry and end in one cycle keep the depth, then one end read back
        step(0, 0, 4'h0, 16'h0000, 1, 0, 1, 0);
        step(0, 0, 4'h0, 16'h0000, 0, 0, 1, 0);
        step(0, 1, 4'h0, 16'h0000, 0, 0, 0, 0);
        // Unsigned, all enables, early exit armed, top bit write of one
        step(1, 0, 4'h0, 16'h1CF8, 0, 0, 0, 0);
        step(0, 1, 4'h0, 16'h0000, 0, 0, 0, 0);
        step(0, 0, 4'h0, 16'h0000, 0, 1, 0, 0);
        step(0, 0, 4'h0, 16'h0000, 0, 1, 0, 0);
        // Depth falls to none and holds
        repeat (9) step(0, 0, 4'h0, 16'h0000, 0, 0, 1, 0);
        step(0, 0, 4'h0, 16'h0000, 1, 0, 1, 0);
        // Top bit set by the core, not cleared through an unmapped place
        step(0, 0, 4'h0, 16'h0000, 0, 0, 0, 1);
        step(1, 0, 4'h5, 16'h0000, 0, 0, 0, 0);
        step(0, 1, 4'h5, 16'h0000, 0, 0, 0, 0);
        step(1, 0, 4'h0, 16'h0000, 0, 0, 0, 0);
        step(0, 1, 4'h0, 16'h0000, 0, 0, 0, 0);
        // Random mix of bus and loop traffic, back to back
        repeat (300) begin
            r0 = $random(seed);
            step(r0[0] & r0[1], ~(r0[0] & r0[1]) & r0[2], r0[3] ? 4'h0 : r0[7:4], r0[31:16],
                 r0[8] & r0[9], r0[10], r0[11] & r0[12],
                 &r0[15:13]);
        end
        step(0, 0, 4'h0, 16'h0000, 0, 0, 0, 0);
        @(negedge i_clk);
        final_report();
    end
endmodule // testbench
